// File: csc_startup_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module csc_startup_cfg (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [csc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll_b_select_strap,
    input wire logic [2:0] pll_b_refclk_freq_strap,
    input wire logic [3:0] cpu_cfg_strap_in,
    output logic [3:0] cpu_cfg_strap_out,
    output logic [3:0] cpu_cfg_strap_oe,
    input wire logic link_ready,
    input wire logic debug_select_n,
    input wire logic pcie_in_valid,
    input wire logic [2:0] pcie_in_bar,
    output logic pcie_route_regs,
    output logic pcie_route_ddr,
    output logic straps_loaded,
    output logic secondary_pll_enable,
    output logic core_clk_from_pll_b,
    output logic pll_b_freq_valid,
    output logic [1:0] pll_b_freq_sel,
    output logic serial_if_cpu_owned,
    output logic serial_slave_enable,
    output logic flash_boot_map_enable,
    output logic cpu_hold_off,
    output logic cpu_big_endian_enable,
    output logic mgmt_slave_enable,
    output logic [4:0] mgmt_slave_addr,
    output logic pcie_ep_enable,
    output logic front_port6_enable,
    output logic front_port0_enable,
    output logic frame_access_port_enable,
    output logic frame_reg_access_enable,
    output logic jtag_to_cpu_debug
);
    import csc_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    csc_state_type state_ff;
    logic [3:0] wait_cnt_ff;
    logic [3:0] cfg_code_ff;
    logic [2:0] ref_code_ff;
    logic pll_sel_ff;
    logic [GC_W-1:0] gen_ctrl_ff;
    logic [GC_W-1:0] nxt_gen_ctrl;
    logic [3:0] cfg_sync;
    logic cfg_stable;
    logic [3:0] ref_sync;
    logic ref_stable;
    logic dbg_sync;
    logic load_evt;
    logic wr_evt;
    logic rd_sel;
    logic [31:0] nxt_rdata;
    logic nxt_err;
    logic [3:0] eff_code;
    logic dec_pcie;
    logic dec_p6;
    logic dec_p0;
    logic dec_fp;
    logic dec_mgmt;
    logic dec_link;
    logic [GC_W-1:0] dec_ctrl;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    csc_sync3 #(.W(4)) u_cfg_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pclk_en(pclk_en),
        .d(cpu_cfg_strap_in),
        .q(cfg_sync),
        .stable(cfg_stable)
    );

    csc_sync3 #(.W(4)) u_ref_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pclk_en(pclk_en),
        .d({pll_b_select_strap, pll_b_refclk_freq_strap}),
        .q(ref_sync),
        .stable(ref_stable)
    );

    csc_sync3 #(.W(1)) u_dbg_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pclk_en(pclk_en),
        .d(!debug_select_n),
        .q(dbg_sync),
        .stable()
    );

    // ************************************************************
    // Strap sampling sequence
    // ************************************************************
    assign load_evt = pclk_en && (state_ff == ST_WAIT) && (wait_cnt_ff >= STRAP_WAIT_CYC)
        && cfg_stable && ref_stable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_WAIT;
            wait_cnt_ff <= CNT_RST;
        end else if (pclk_en) begin
            case (state_ff)
                ST_WAIT: begin
                    if (load_evt) begin
                        state_ff <= ST_RUN;
                    end else if (wait_cnt_ff < STRAP_WAIT_CYC) begin
                        wait_cnt_ff <= wait_cnt_ff + 4'h1;
                    end
                end
                ST_RUN: begin
                    state_ff <= ST_RUN;
                end
                default: begin
                    state_ff <= ST_WAIT;
                end
            endcase
        end
    end

    // Straps latched once, held until the next reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_code_ff <= CFG_STRAP_RST;
            ref_code_ff <= REF_STRAP_RST;
            pll_sel_ff <= 1'b0;
        end else if (load_evt) begin
            cfg_code_ff <= cfg_sync;
            ref_code_ff <= ref_sync[2:0];
            pll_sel_ff <= ref_sync[3];
        end
    end

    // ************************************************************
    // Strap code decode
    // ************************************************************
    always_comb begin
        eff_code = load_evt ? cfg_sync : cfg_code_ff;
        dec_pcie = 1'b0;
        dec_p6 = 1'b0;
        dec_p0 = 1'b0;
        dec_fp = 1'b0;
        dec_mgmt = 1'b0;
        dec_ctrl = '0;
        dec_ctrl[GC_HOLD_OFF] = 1'b1;
        case (eff_code)
            CFG_LE_BOOT: begin
                dec_ctrl[GC_HOLD_OFF] = 1'b0;
                dec_ctrl[GC_BOOT_MAP] = 1'b1;
                dec_ctrl[GC_SI_OWNED] = 1'b1;
            end
            CFG_BE_BOOT: begin
                dec_ctrl[GC_HOLD_OFF] = 1'b0;
                dec_ctrl[GC_BOOT_MAP] = 1'b1;
                dec_ctrl[GC_SI_OWNED] = 1'b1;
                dec_ctrl[GC_BIG_END] = 1'b1;
            end
            CFG_PCIE_P6: begin
                dec_pcie = 1'b1;
                dec_p6 = 1'b1;
                dec_fp = 1'b1;
            end
            CFG_PCIE_P0: begin
                dec_pcie = 1'b1;
                dec_p0 = 1'b1;
                dec_fp = 1'b1;
            end
            CFG_PCIE_FP: begin
                dec_pcie = 1'b1;
                dec_fp = 1'b1;
            end
            CFG_MGMT: begin
                dec_mgmt = 1'b1;
                dec_ctrl[GC_MGMT_EN] = 1'b1;
            end
            default: begin
                dec_ctrl[GC_HOLD_OFF] = 1'b1;
            end
        endcase
        dec_link = dec_pcie | dec_p6 | dec_p0 | dec_fp;
    end

    // ************************************************************
    // General control register
    // ************************************************************
    assign wr_evt = pclk_en && psel && penable && pready && pwrite && (paddr == GEN_CTRL_OFS)
        && (state_ff == ST_RUN);

    always_comb begin
        nxt_gen_ctrl = gen_ctrl_ff;
        if (load_evt) begin
            nxt_gen_ctrl = dec_ctrl;
        end else if (wr_evt) begin
            nxt_gen_ctrl = pwdata[GC_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_ctrl_ff <= GEN_CTRL_RST;
        end else if (pclk_en) begin
            gen_ctrl_ff <= nxt_gen_ctrl;
        end
    end

    // ************************************************************
    // APB slave, one wait state
    // ************************************************************
    assign rd_sel = psel && penable && !pready;

    always_comb begin
        nxt_rdata = RDATA_RST;
        nxt_err = 1'b0;
        case (paddr)
            GEN_CTRL_OFS: begin
                nxt_rdata[GC_W-1:0] = gen_ctrl_ff;
            end
            STRAP_STAT_OFS: begin
                nxt_rdata[3:0] = cfg_code_ff;
                nxt_rdata[6:4] = ref_code_ff;
                nxt_rdata[7] = pll_sel_ff;
                nxt_rdata[8] = (state_ff == ST_RUN);
            end
            PORT_STAT_OFS: begin
                nxt_rdata[0] = pcie_ep_enable;
                nxt_rdata[1] = front_port6_enable;
                nxt_rdata[2] = front_port0_enable;
                nxt_rdata[3] = frame_access_port_enable;
                nxt_rdata[4] = mgmt_slave_enable;
                nxt_rdata[5] = link_ready;
                nxt_rdata[6] = jtag_to_cpu_debug;
            end
            default: begin
                nxt_err = 1'b1;
            end
        endcase
        if (pwrite) begin
            nxt_rdata = RDATA_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= RDATA_RST;
            pslverr <= 1'b0;
        end else if (pclk_en) begin
            pready <= rd_sel;
            prdata <= rd_sel ? nxt_rdata : RDATA_RST;
            pslverr <= rd_sel && nxt_err;
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_if_cpu_owned <= 1'b0;
            serial_slave_enable <= 1'b0;
            flash_boot_map_enable <= 1'b1;
            cpu_hold_off <= 1'b1;
            cpu_big_endian_enable <= 1'b0;
            mgmt_slave_enable <= 1'b0;
        end else if (pclk_en) begin
            serial_if_cpu_owned <= nxt_gen_ctrl[GC_SI_OWNED];
            serial_slave_enable <= (state_ff == ST_RUN || load_evt)
                && !nxt_gen_ctrl[GC_SI_OWNED];
            flash_boot_map_enable <= nxt_gen_ctrl[GC_BOOT_MAP];
            cpu_hold_off <= nxt_gen_ctrl[GC_HOLD_OFF];
            cpu_big_endian_enable <= nxt_gen_ctrl[GC_BIG_END];
            mgmt_slave_enable <= nxt_gen_ctrl[GC_MGMT_EN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            straps_loaded <= 1'b0;
            pcie_ep_enable <= 1'b0;
            front_port6_enable <= 1'b0;
            front_port0_enable <= 1'b0;
            frame_access_port_enable <= 1'b0;
            frame_reg_access_enable <= 1'b0;
            mgmt_slave_addr <= MGMT_ADDR_RST;
        end else if (pclk_en && (state_ff == ST_RUN || load_evt)) begin
            straps_loaded <= 1'b1;
            pcie_ep_enable <= dec_pcie;
            front_port6_enable <= dec_p6;
            front_port0_enable <= dec_p0;
            frame_access_port_enable <= dec_fp;
            frame_reg_access_enable <= dec_fp;
            mgmt_slave_addr <= dec_mgmt ? MGMT_ADDR_STRAP : MGMT_ADDR_RST;
        end
    end

    // Secondary PLL and reference frequency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secondary_pll_enable <= 1'b0;
            core_clk_from_pll_b <= 1'b0;
            pll_b_freq_valid <= 1'b0;
            pll_b_freq_sel <= FREQ_125;
        end else if (pclk_en) begin
            secondary_pll_enable <= pll_sel_ff;
            core_clk_from_pll_b <= pll_sel_ff;
            pll_b_freq_valid <= 1'b0;
            pll_b_freq_sel <= FREQ_125;
            if (pll_sel_ff && state_ff == ST_RUN) begin
                pll_b_freq_valid <= 1'b1;
                case (ref_code_ff)
                    REF_125: pll_b_freq_sel <= FREQ_125;
                    REF_156: pll_b_freq_sel <= FREQ_156_25;
                    REF_250: pll_b_freq_sel <= FREQ_250;
                    REF_25: pll_b_freq_sel <= FREQ_25;
                    default: pll_b_freq_valid <= 1'b0;
                endcase
            end
        end
    end

    // Strap pins, debug mux and PCIe routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_cfg_strap_out <= 4'h0;
            cpu_cfg_strap_oe <= 4'h0;
            jtag_to_cpu_debug <= 1'b0;
            pcie_route_regs <= 1'b0;
            pcie_route_ddr <= 1'b0;
        end else if (pclk_en) begin
            cpu_cfg_strap_out <= {2'b11, 2'b00};
            cpu_cfg_strap_oe <= {{2{state_ff == ST_RUN && dec_link && link_ready}},
                2'b00};
            jtag_to_cpu_debug <= dbg_sync;
            pcie_route_regs <= pcie_in_valid && pcie_in_bar == BAR_REGS
                && pcie_ep_enable;
            pcie_route_ddr <= pcie_in_valid && pcie_in_bar == BAR_DDR
                && pcie_ep_enable;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    logic [7:0] since_rst_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_rst_ff <= SINCE_RST;
        end else if (pclk_en && since_rst_ff != 8'hff) begin
            since_rst_ff <= since_rst_ff + 8'h01;
        end
    end

    property p_freq_156;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && pll_sel_ff && state_ff == ST_RUN && ref_code_ff == REF_156)
            |=> (pll_b_freq_valid && pll_b_freq_sel == FREQ_156_25);
    endproperty
    a_freq_156: assert property (p_freq_156) else $error("bad pll freq decode");

    property p_freq_ignore;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && !pll_sel_ff) |=> !pll_b_freq_valid;
    endproperty
    a_freq_ignore: assert property (p_freq_ignore) else $error("freq valid without pll");

    property p_le_boot;
        @(posedge pclk) disable iff (!presetn)
        (load_evt && cfg_sync == CFG_LE_BOOT)
            |=> (!cpu_hold_off && !cpu_big_endian_enable && !serial_slave_enable);
    endproperty
    a_le_boot: assert property (p_le_boot) else $error("little endian boot wrong");

    property p_be_boot;
        @(posedge pclk) disable iff (!presetn)
        (load_evt && cfg_sync == CFG_BE_BOOT)
            |=> (!cpu_hold_off && cpu_big_endian_enable && serial_if_cpu_owned);
    endproperty
    a_be_boot: assert property (p_be_boot) else $error("big endian boot wrong");

    property p_pcie_p6;
        @(posedge pclk) disable iff (!presetn)
        (load_evt && cfg_sync == CFG_PCIE_P6) |=> (pcie_ep_enable && front_port6_enable
            && frame_reg_access_enable && cpu_hold_off && serial_slave_enable);
    endproperty
    a_pcie_p6: assert property (p_pcie_p6) else $error("code 0010 wrong");

    property p_mgmt;
        @(posedge pclk) disable iff (!presetn)
        (load_evt && cfg_sync == CFG_MGMT)
            |=> (mgmt_slave_enable && mgmt_slave_addr == MGMT_ADDR_STRAP && cpu_hold_off);
    endproperty
    a_mgmt: assert property (p_mgmt) else $error("code 1010 wrong");

    property p_sample_delay;
        @(posedge pclk) disable iff (!presetn)
        load_evt |-> since_rst_ff >= {4'h0, STRAP_WAIT_CYC};
    endproperty
    a_sample_delay: assert property (p_sample_delay) else $error("straps sampled early");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (state_ff == ST_RUN) |=> $stable(cfg_code_ff) && $stable(ref_code_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("latched strap changed");

    property p_si_slave;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && state_ff == ST_RUN) |=> (serial_slave_enable == !gen_ctrl_ff[GC_SI_OWNED]);
    endproperty
    a_si_slave: assert property (p_si_slave) else $error("serial slave not inverse");

    property p_jtag;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && !dbg_sync) |=> !jtag_to_cpu_debug;
    endproperty
    a_jtag: assert property (p_jtag) else $error("jtag select wrong");

    property p_route;
        @(posedge pclk) disable iff (!presetn)
        (pclk_en && pcie_in_valid && pcie_ep_enable && pcie_in_bar == BAR_DDR)
            |=> (pcie_route_ddr && !pcie_route_regs);
    endproperty
    a_route: assert property (p_route) else $error("pcie routing wrong");

    c_le_boot: cover property (@(posedge pclk) load_evt && cfg_sync == CFG_LE_BOOT);
    c_host_write: cover property (@(posedge pclk) wr_evt);
    c_link_drive: cover property (@(posedge pclk) cpu_cfg_strap_oe[3]);
endmodule : csc_startup_cfg
`default_nettype wire

// File: csc_pkg.sv
`default_nettype none
package csc_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int STRAP_DELAY_NS = 100;
    localparam int STRAP_WAIT_CYC_I = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] STRAP_WAIT_CYC = 4'(STRAP_WAIT_CYC_I);
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [7:0] SINCE_RST = 8'h00;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] GEN_CTRL_OFS = 12'h000;
    localparam logic [11:0] STRAP_STAT_OFS = 12'h004;
    localparam logic [11:0] PORT_STAT_OFS = 12'h008;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // General control field positions
    localparam int GC_SI_OWNED = 0;
    localparam int GC_BOOT_MAP = 1;
    localparam int GC_HOLD_OFF = 2;
    localparam int GC_BIG_END = 3;
    localparam int GC_MGMT_EN = 4;
    localparam int GC_W = 5;
    // Value before straps are loaded
    localparam logic [4:0] GEN_CTRL_RST = 5'h06;

    // ************************************************************
    // Strap codes
    // ************************************************************
    localparam logic [3:0] CFG_LE_BOOT = 4'h0;
    localparam logic [3:0] CFG_PCIE_P6 = 4'h2;
    localparam logic [3:0] CFG_PCIE_P0 = 4'h3;
    localparam logic [3:0] CFG_PCIE_FP = 4'h8;
    localparam logic [3:0] CFG_MGMT = 4'ha;
    localparam logic [3:0] CFG_BE_BOOT = 4'hc;
    localparam logic [3:0] CFG_NO_BOOT = 4'hf;
    localparam logic [3:0] CFG_STRAP_RST = 4'hf;

    localparam logic [2:0] REF_125 = 3'h0;
    localparam logic [2:0] REF_156 = 3'h1;
    localparam logic [2:0] REF_250 = 3'h2;
    localparam logic [2:0] REF_25 = 3'h4;
    localparam logic [2:0] REF_STRAP_RST = 3'h0;

    typedef enum logic [1:0] {
        FREQ_125,
        FREQ_156_25,
        FREQ_250,
        FREQ_25
    } csc_freq_type;

    localparam logic [4:0] MGMT_ADDR_STRAP = 5'h00;
    localparam logic [4:0] MGMT_ADDR_RST = 5'h00;

    // Inbound PCIe regions
    localparam logic [2:0] BAR_REGS = 3'h0;
    localparam logic [2:0] BAR_DDR = 3'h2;

    typedef enum logic {
        ST_WAIT,
        ST_RUN
    } csc_state_type;
endpackage : csc_pkg
`default_nettype wire

// File: csc_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module csc_sync3 #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic stable
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    // ************************************************************
    // Three-stage synchroniser
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else if (pclk_en) begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign q = s3_ff;
    assign stable = (s2_ff == s3_ff);
endmodule : csc_sync3
`default_nettype wire

// File: csc_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module csc_board_model (
    input wire logic [3:0] cfg_code,
    input wire logic [3:0] strap_out,
    input wire logic [3:0] strap_oe,
    output logic [3:0] strap_pin
);
    // ************************************************************
    // Strap resistors, overridden where the device drives
    // ************************************************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            strap_pin[i] = strap_oe[i] ? strap_out[i] : cfg_code[i];
        end
    end
endmodule : csc_board_model
`default_nettype wire

// File: tb_csc_startup_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module tb_csc_startup_cfg;
    import csc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, pv = 1'b0, dbg_n = 1'b1, sel_s = 1'b0, lrdy = 1'b1;
    logic [2:0] ref_s = 3'h0, bar = 3'h0;
    logic [3:0] code = 4'h0, s_out, s_oe, s_pin;
    logic rr, rdd, ld, fv, own, sse, map, hold, be, mg, pe, p6, p0, fap, fra, jt;
    logic [1:0] fs;
    logic spe, ccb, en = 1'b1;
    logic [4:0] mga;
    int miscompares = 0;
    int samples_checked = 0;
    logic [3:0] codes [8] = '{4'h0, 4'hc, 4'h2, 4'h3, 4'h8, 4'ha, 4'hf, 4'h9};
    logic [2:0] refs [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h0, 3'h1, 3'h2};
    csc_board_model csc_board_model_inst (.cfg_code(code), .strap_out(s_out), .strap_oe(s_oe),
        .strap_pin(s_pin));
    csc_startup_cfg csc_startup_cfg_inst (.pclk(pclk), .presetn(presetn), .pclk_en(en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pll_b_select_strap(sel_s),
        .pll_b_refclk_freq_strap(ref_s), .cpu_cfg_strap_in(s_pin), .cpu_cfg_strap_out(s_out),
        .cpu_cfg_strap_oe(s_oe), .link_ready(lrdy), .debug_select_n(dbg_n),
        .pcie_in_valid(pv), .pcie_in_bar(bar), .pcie_route_regs(rr), .pcie_route_ddr(rdd),
        .straps_loaded(ld), .secondary_pll_enable(spe), .core_clk_from_pll_b(ccb),
        .pll_b_freq_valid(fv), .pll_b_freq_sel(fs), .serial_if_cpu_owned(own),
        .serial_slave_enable(sse), .flash_boot_map_enable(map), .cpu_hold_off(hold),
        .cpu_big_endian_enable(be), .mgmt_slave_enable(mg), .mgmt_slave_addr(mga),
        .pcie_ep_enable(pe), .front_port6_enable(p6), .front_port0_enable(p0),
        .frame_access_port_enable(fap), .frame_reg_access_enable(fra), .jtag_to_cpu_debug(jt));
    // ************************************************************
    // Clock, access tasks and comparison
    // ************************************************************
    initial begin
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : apb
    task automatic boot(input logic [3:0] c, input logic s, input logic [2:0] r);
        @(posedge pclk);
        code <= c;
        sel_s <= s;
        ref_s <= r;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        while (ld !== 1'b1) begin
            @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask : boot
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic f, lk, v;
        logic [3:0] xb;
        logic [5:0] xp;
        for (int i = 0; i < 8; i++) begin
            boot(codes[i], i != 5, refs[i]);
            f = codes[i] == 4'h0 || codes[i] == 4'hc;
            lk = codes[i] == 4'h2 || codes[i] == 4'h3 || codes[i] == 4'h8;
            v = i != 5 && refs[i] != 3'h3;
            xb = {!f, codes[i] == 4'hc, f, !f};
            xp = {lk, codes[i] == 4'h2, codes[i] == 4'h3, codes[i] == 4'ha, lk, lk};
            for (int k = 0; k < 2; k++) begin
                chk("boot_ctrl", {hold, be, own, sse}, xb);
                chk("ports", {pe, p6, p0, mg, fap, fra}, xp);
                code <= ~codes[i];
                repeat (8) @(posedge pclk);
            end
            chk("freq_valid", fv, v);
            if (v) chk("freq_sel", fs, refs[i] == 3'h4 ? 2'h3 : refs[i][1:0]);
            chk("pll_src", {spe, ccb}, {2{i != 5}});
            chk("mgmt_addr", mga, 32'h0);
            chk("strap_oe", s_oe, {lk, lk, 2'b00});
            lrdy <= 1'b0;
            repeat (2) @(posedge pclk);
            chk("strap_oe_idle", s_oe, 4'h0);
            lrdy <= 1'b1;
            apb(1'b0, GEN_CTRL_OFS, 32'h0);
            chk("gen_ctrl", rd, {xp[2], xb[2], !f, f, f});
            apb(1'b0, STRAP_STAT_OFS, 32'h0);
            chk("strap_stat", rd, {23'h0, 1'b1, i != 5, refs[i], codes[i]});
            for (int b = 0; b < 3; b += 2) begin
                @(posedge pclk);
                pv <= 1'b1;
                bar <= 3'(b);
                @(posedge pclk);
                pv <= 1'b0;
                @(posedge pclk);
                chk("route", {rr, rdd}, {lk && b == 0, lk && b == 2});
            end
            $display("test strap code %h done", codes[i]);
        end
        chk("strap_out", s_out, 4'hc);
        apb(1'b0, PORT_STAT_OFS, 32'h0);
        chk("port_stat", rd, 32'h0000_0020);
        apb(1'b1, GEN_CTRL_OFS, 32'h0000_000b);
        chk("flash_boot", {own, sse, map, hold, be}, 5'b10101);
        apb(1'b1, GEN_CTRL_OFS, 32'h0000_0010);
        chk("ddr_boot", {own, sse, map, hold, be, mg}, 6'b010001);
        apb(1'b0, GEN_CTRL_OFS, 32'h0);
        chk("gen_ctrl_rd", rd, 32'h0000_0010);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped_err", er, 1'b1);
        chk("unmapped_rd", rd, 32'h0);
        $display("test host control done");
        en <= 1'b0;
        dbg_n <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("jtag_frozen", jt, 1'b0);
        en <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("jtag_low", jt, 1'b1);
        dbg_n <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("jtag_high", jt, 1'b0);
        $display("test debug select done");
        print_verdict();
    end
endmodule : tb_csc_startup_cfg
`default_nettype wire
